// file: shared/ppbp_pkg.sv
// constants shared by both ends of the parallel processor bus port
// assumes: 9-bit register address, 8-bit data, one clock for everything
package ppbp_pkg;
	localparam int ADDR_W = 9;
	localparam int DATA_W = 8;
	localparam int SEL_W  = 3;

	// host_bus_select codes: style and address multiplexing
	localparam logic [2:0] SEL_MUX_PAIR = 3'h2;
	localparam logic [2:0] SEL_NMX_PAIR = 3'h3;
	localparam logic [2:0] SEL_NMX_DIR  = 3'h4;
	localparam logic [2:0] SEL_MUX_DIR  = 3'h6;

	// device end: own registers at the top of the address space
	localparam logic [8:0] DEV_IRQ_CONFIG = 9'h1fc;
	localparam logic [8:0] DEV_IRQ_STATUS = 9'h1fd;
	localparam logic [8:0] DEV_IRQ_ENABLE = 9'h1fe;
	localparam logic [8:0] DEV_IRQ_CLEAR  = 9'h1ff;
	// irq_config fields and reset value (active low, push-pull)
	localparam int CFG_POL     = 0;
	localparam int CFG_ODRAIN  = 1;
	localparam int CFG_GPO     = 2;
	localparam int CFG_GPO_VAL = 3;
	localparam logic [7:0] IRQ_CONFIG_RST = 8'h00;

	// host end: AXI4-Lite register offsets
	localparam int AXI_AW = 8;
	localparam logic [7:0] HOST_CMD        = 8'h00;
	localparam logic [7:0] HOST_WDATA      = 8'h04;
	localparam logic [7:0] HOST_RDATA      = 8'h08;
	localparam logic [7:0] HOST_STATUS     = 8'h0c;
	localparam logic [7:0] HOST_CFG        = 8'h10;
	localparam logic [7:0] HOST_INT_STATUS = 8'h14;
	localparam logic [7:0] HOST_INT_ENABLE = 8'h18;
	localparam logic [7:0] HOST_INT_CLEAR  = 8'h1c;
	localparam int CMD_READ     = 9;
	localparam int HCFG_IRQ_POL = 3;
	localparam logic [3:0] HOST_CFG_RST = 4'h3;
	localparam int INT_DONE = 0;
	localparam int INT_PIN  = 1;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	function automatic logic ppbp_is_mux(input logic [2:0] sel);
		ppbp_is_mux = (sel == SEL_MUX_PAIR) || (sel == SEL_MUX_DIR);
	endfunction

	function automatic logic ppbp_is_dir(input logic [2:0] sel);
		ppbp_is_dir = (sel == SEL_NMX_DIR) || (sel == SEL_MUX_DIR);
	endfunction

	function automatic logic ppbp_is_valid(input logic [2:0] sel);
		ppbp_is_valid = ppbp_is_mux(sel) || ppbp_is_dir(sel) || (sel == SEL_NMX_PAIR);
	endfunction
endpackage

// file: shared/ppbp_if.sv
// pins between host controller and device port
// assumes: shared lines float high when nobody drives; irq pin pulled up
`timescale 1ns/1ps
interface ppbp_if;
	import ppbp_pkg::*;
	logic              ale;
	logic              cs_n;
	logic              wr_dir;
	logic              strobe_n;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] host_ad_o;
	logic              host_ad_oe;
	logic [DATA_W-1:0] dev_ad_o;
	logic              dev_ad_oe;
	logic [DATA_W-1:0] ad;
	logic              ready_n;
	logic              irq_o;
	logic              irq_oe;
	logic              irq_pin;
	logic [SEL_W-1:0]  host_bus_select;

	// wire resolution; device wins only to keep the level defined on a clash
	assign ad      = dev_ad_oe ? dev_ad_o : (host_ad_oe ? host_ad_o : '1);
	assign irq_pin = irq_oe ? irq_o : 1'b1;

	modport dev (
		input  ale, cs_n, wr_dir, strobe_n, addr, ad, host_bus_select,
		output dev_ad_o, dev_ad_oe, ready_n, irq_o, irq_oe
	);
	modport host (
		output ale, cs_n, wr_dir, strobe_n, addr, host_ad_o, host_ad_oe, host_bus_select,
		input  ad, ready_n, irq_pin
	);
endinterface

// file: logic/ppbp_dev.sv
// parallel host port, device end: address latch, strobe decode, ready, irq pin
// assumes: pins synchronous to CLK; user answers REG_RDATA in the REG_RD cycle
`timescale 1ns/1ps
module ppbp_dev #(
	parameter int N_EVT = 8
) (
	input  wire logic                         CLK,
	input  wire logic                         RST,
	ppbp_if.dev                               bus,
	output logic     [ppbp_pkg::ADDR_W-1:0]   REG_ADDR,
	output logic     [ppbp_pkg::DATA_W-1:0]   REG_WDATA,
	output logic                              REG_WR,
	output logic                              REG_RD,
	input  wire logic [ppbp_pkg::DATA_W-1:0]  REG_RDATA,
	input  wire logic [N_EVT-1:0]             IRQ_EVENTS,
	output logic     [ppbp_pkg::SEL_W-1:0]    BUS_MODE
);
	import ppbp_pkg::*;

	// status register is one byte wide
	if (N_EVT < 1 || N_EVT > DATA_W) begin : g_chk
		$error("ppbp_dev: N_EVT must be 1..8");
	end

	typedef enum logic [3:0] {
		D_IDLE  = 4'b0001,
		D_FETCH = 4'b0010,
		D_READ  = 4'b0100,
		D_WRITE = 4'b1000
	} ppbp_dst_t;

	typedef struct packed {
		ppbp_dst_t         st;
		logic              mode_ok;
		logic [SEL_W-1:0]  mode;
		logic [ADDR_W-1:0] alat;
		logic [ADDR_W-1:0] acc;
		logic              own;
		logic [DATA_W-1:0] dout;
		logic              oe;
		logic              ready_n;
		logic [DATA_W-1:0] wd;
		logic [DATA_W-1:0] cfg;
		logic [DATA_W-1:0] stat;
		logic [DATA_W-1:0] en;
		logic              irq_o;
		logic              irq_oe;
		logic              uw;
		logic              ur;
		logic [DATA_W-1:0] uwd;
	} ppbp_dev_t;

	localparam ppbp_dev_t D_RST = '{
		st: D_IDLE, cfg: IRQ_CONFIG_RST, ready_n: 1'b1,
		irq_o: 1'b1, irq_oe: 1'b1, default: '0
	};

	ppbp_dev_t s;
	ppbp_dev_t next_s;

	logic              mux;
	logic              dir;
	logic              sel;
	logic              rd_req;
	logic              wr_req;
	logic [ADDR_W-1:0] src;
	logic [ADDR_W-1:0] eff;
	logic [DATA_W-1:0] evt;
	logic [DATA_W-1:0] clr;
	logic              act;
	logic              lvl;

	function automatic logic is_own(input logic [ADDR_W-1:0] a);
		is_own = (a == DEV_IRQ_CONFIG) || (a == DEV_IRQ_STATUS) ||
		         (a == DEV_IRQ_ENABLE) || (a == DEV_IRQ_CLEAR);
	endfunction

	// strobe and address decode from the latched mode
	always_comb begin
		mux    = ppbp_is_mux(s.mode);
		dir    = ppbp_is_dir(s.mode);
		sel    = !bus.cs_n && s.mode_ok && ppbp_is_valid(s.mode);
		src    = mux ? {bus.addr[ADDR_W-1], bus.ad} : bus.addr;
		eff    = bus.ale ? src : s.alat; // transparent while high
		rd_req = dir ? (!bus.strobe_n && bus.wr_dir) : !bus.strobe_n;
		wr_req = dir ? (!bus.strobe_n && !bus.wr_dir) : !bus.wr_dir;
		evt    = '0;
		evt[N_EVT-1:0] = IRQ_EVENTS;
	end

	// next state of the whole port
	always_comb begin
		next_s    = s;
		next_s.uw = 1'b0;
		next_s.ur = 1'b0;
		clr       = '0;
		// catch the select pins on the first edge after reset release
		if (!s.mode_ok) begin
			next_s.mode_ok = 1'b1;
			next_s.mode    = bus.host_bus_select;
		end
		if (bus.ale) begin
			next_s.alat = src;
		end
		case (s.st)
			D_IDLE: begin
				if (sel && rd_req) begin
					next_s.st  = D_FETCH;
					next_s.acc = eff;
					next_s.own = is_own(eff);
					next_s.ur  = !is_own(eff);
					next_s.oe  = 1'b1;
				end else if (sel && wr_req) begin
					next_s.st      = D_WRITE;
					next_s.acc     = eff;
					next_s.own     = is_own(eff);
					next_s.wd      = bus.ad;
					next_s.ready_n = 1'b0; // write accepted
				end
			end
			D_FETCH: begin
				// user data arrives in the cycle its read pulse is high
				case (s.acc)
					DEV_IRQ_CONFIG: next_s.dout = s.cfg;
					DEV_IRQ_STATUS: next_s.dout = s.stat;
					DEV_IRQ_ENABLE: next_s.dout = s.en;
					DEV_IRQ_CLEAR:  next_s.dout = '0;
					default:        next_s.dout = REG_RDATA;
				endcase
				if (sel && rd_req) begin
					next_s.st      = D_READ;
					next_s.ready_n = 1'b0;
				end else begin
					next_s.st = D_IDLE;
					next_s.oe = 1'b0;
				end
			end
			D_READ: begin
				// hold data until the strobe or the select goes away
				if (!(sel && rd_req)) begin
					next_s.st      = D_IDLE;
					next_s.oe      = 1'b0;
					next_s.ready_n = 1'b1;
				end
			end
			D_WRITE: begin
				if (sel && wr_req) begin
					next_s.wd = bus.ad; // last value before release wins
				end else begin
					// commit on strobe release: data held through the low phase
					next_s.st      = D_IDLE;
					next_s.ready_n = 1'b1;
					if (s.own) begin
						case (s.acc)
							DEV_IRQ_CONFIG: next_s.cfg = s.wd;
							DEV_IRQ_ENABLE: next_s.en = s.wd;
							DEV_IRQ_CLEAR:  clr = s.wd;
							default:        next_s.cfg = s.cfg;
						endcase
					end else begin
						next_s.uw  = 1'b1;
						next_s.uwd = s.wd;
					end
				end
			end
			default: begin
				next_s.st      = D_IDLE;
				next_s.oe      = 1'b0;
				next_s.ready_n = 1'b1;
			end
		endcase
		// sticky events; a new event beats a clear in the same cycle
		next_s.stat = (s.stat & ~clr) | evt;
		act = |(s.stat & s.en);
		lvl = s.cfg[CFG_GPO] ? s.cfg[CFG_GPO_VAL]
		                     : (act ? s.cfg[CFG_POL] : !s.cfg[CFG_POL]);
		if (s.cfg[CFG_ODRAIN]) begin
			next_s.irq_o  = 1'b0; // only pulls low
			next_s.irq_oe = !lvl;
		end else begin
			next_s.irq_o  = lvl;
			next_s.irq_oe = 1'b1;
		end
	end

	// single state register
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			s <= D_RST;
		end else begin
			s <= next_s;
		end
	end

	// pins and user side straight from flip-flops
	assign bus.dev_ad_o  = s.dout;
	assign bus.dev_ad_oe = s.oe;
	assign bus.ready_n   = s.ready_n;
	assign bus.irq_o     = s.irq_o;
	assign bus.irq_oe    = s.irq_oe;
	assign REG_ADDR      = s.acc;
	assign REG_WDATA     = s.uwd;
	assign REG_WR        = s.uw;
	assign REG_RD        = s.ur;
	assign BUS_MODE      = s.mode;
endmodule

// file: logic/ppbp_host.sv
// parallel host port, controller end: AXI4-Lite orders become pin cycles
// assumes: device answers with ready; mode pins take effect at device reset
//
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module ppbp_host (
	input  wire logic                        CLK,
	input  wire logic                        RST,
	ppbp_if.host                             bus,
	input  wire logic                        AWVALID,
	output logic                             AWREADY,
	input  wire logic [ppbp_pkg::AXI_AW-1:0] AWADDR,
	input  wire logic                        WVALID,
	output logic                             WREADY,
	input  wire logic [31:0]                 WDATA,
	input  wire logic [3:0]                  WSTRB,
	output logic                             BVALID,
	input  wire logic                        BREADY,
	output logic     [1:0]                   BRESP,
	input  wire logic                        ARVALID,
	output logic                             ARREADY,
	input  wire logic [ppbp_pkg::AXI_AW-1:0] ARADDR,
	output logic                             RVALID,
	input  wire logic                        RREADY,
	output logic     [31:0]                  RDATA,
	output logic     [1:0]                   RRESP,
	output logic                             IRQ
);
	import ppbp_pkg::*;

	typedef enum logic [3:0] {
		H_IDLE = 4'b0001,
		H_ADDR = 4'b0010,
		H_STRB = 4'b0100,
		H_END  = 4'b1000
	} ppbp_hst_t;

	typedef struct packed {
		ppbp_hst_t         st;
		logic              aw_got;
		logic              w_got;
		logic [AXI_AW-1:0] awa;
		logic [31:0]       wd;
		logic [3:0]        ws;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
		logic [ADDR_W-1:0] cmd_addr;
		logic              cmd_rd;
		logic [DATA_W-1:0] wbyte;
		logic [DATA_W-1:0] rbyte;
		logic [3:0]        cfg;
		logic [1:0]        istat;
		logic [1:0]        ien;
		logic              irq;
		logic              ale;
		logic              cs_n;
		logic              wr_dir;
		logic              strobe_n;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] ad_o;
		logic              ad_oe;
	} ppbp_host_t;

	localparam ppbp_host_t H_RST = '{
		st: H_IDLE, cfg: HOST_CFG_RST, ale: 1'b1, cs_n: 1'b1,
		wr_dir: 1'b1, strobe_n: 1'b1, default: '0
	};

	ppbp_host_t  s;
	ppbp_host_t  next_s;
	logic        mux;
	logic        dir;
	logic        busy;
	logic        pin_act;
	logic        wr_ok;
	logic [1:0]  ev;
	logic [1:0]  clr;
	logic [33:0] wr_look;

	// register read mux; unmapped offsets answer with an error
	function automatic logic [33:0] rd_reg(input ppbp_host_t h, input logic [AXI_AW-1:0] a);
		rd_reg = {RESP_OKAY, 32'h0};
		case (a)
			HOST_CMD:        rd_reg[31:0] = {22'h0, h.cmd_rd, h.cmd_addr};
			HOST_WDATA:      rd_reg[31:0] = {24'h0, h.wbyte};
			HOST_RDATA:      rd_reg[31:0] = {24'h0, h.rbyte};
			HOST_STATUS:     rd_reg[31:0] = {30'h0, pin_act, busy};
			HOST_CFG:        rd_reg[31:0] = {28'h0, h.cfg};
			HOST_INT_STATUS: rd_reg[31:0] = {30'h0, h.istat};
			HOST_INT_ENABLE: rd_reg[31:0] = {30'h0, h.ien};
			HOST_INT_CLEAR:  rd_reg[31:0] = 32'h0;
			default:         rd_reg[33:32] = RESP_SLVERR;
		endcase
	endfunction

	// channel readies are plain combinational handshakes
	assign AWREADY = !s.aw_got && !s.bvalid;
	assign WREADY  = !s.w_got && !s.bvalid;
	assign ARREADY = !s.rvalid;

	always_comb begin
		next_s  = s;
		mux     = ppbp_is_mux(s.cfg[2:0]);
		dir     = ppbp_is_dir(s.cfg[2:0]);
		busy    = (s.st != H_IDLE);
		pin_act = s.cfg[HCFG_IRQ_POL] ? bus.irq_pin : !bus.irq_pin;
		ev      = {pin_act, 1'b0};
		clr     = '0;
		wr_ok   = 1'b0;
		// decode of the held write address; its response field answers the write
		wr_look = rd_reg(s, s.awa);
		if (AWVALID && AWREADY) begin
			next_s.aw_got = 1'b1;
			next_s.awa    = AWADDR;
		end
		if (WVALID && WREADY) begin
			next_s.w_got = 1'b1;
			next_s.wd    = WDATA;
			next_s.ws    = WSTRB;
		end
		// write commits once both address and data are held
		if (s.aw_got && s.w_got) begin
			next_s.aw_got = 1'b0;
			next_s.w_got  = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp  = wr_look[33:32];
			wr_ok         = s.ws[0];
		end
		if (s.bvalid && BREADY) begin
			next_s.bvalid = 1'b0;
		end
		if (ARVALID && ARREADY) begin
			next_s.rvalid = 1'b1;
			{next_s.rresp, next_s.rdata} = rd_reg(s, ARADDR);
		end else if (s.rvalid && RREADY) begin
			next_s.rvalid = 1'b0;
		end
		// register writes; command and mode are refused while a cycle runs
		if (wr_ok) begin
			case (s.awa)
				HOST_WDATA:      next_s.wbyte = s.wd[7:0];
				HOST_CFG:        next_s.cfg = busy ? s.cfg : s.wd[3:0];
				HOST_INT_ENABLE: next_s.ien = s.wd[1:0];
				HOST_INT_CLEAR:  clr = s.wd[1:0];
				default:         next_s.cfg = s.cfg;
			endcase
		end
		case (s.st)
			H_IDLE: begin
				next_s.ale = !mux; // latch kept transparent unless multiplexed
				if (wr_ok && s.awa == HOST_CMD && s.ws[1]) begin
					next_s.cmd_addr = s.wd[ADDR_W-1:0];
					next_s.cmd_rd   = s.wd[CMD_READ];
					next_s.st       = H_ADDR;
					next_s.cs_n     = 1'b0;
					next_s.ale      = 1'b1;
					// low address pins held at zero when multiplexed
					next_s.addr  = mux ? {s.wd[ADDR_W-1], 8'h00} : s.wd[ADDR_W-1:0];
					next_s.ad_o  = s.wd[7:0];
					next_s.ad_oe = mux;
					next_s.wr_dir = dir ? s.wd[CMD_READ] : 1'b1;
				end
			end
			H_ADDR: begin
				next_s.st    = H_STRB;
				next_s.ale   = !mux; // close the latch in the same cycle the data goes out when multiplexed
				next_s.ad_o  = s.wbyte;
				next_s.ad_oe = !s.cmd_rd;
				if (dir || s.cmd_rd) begin
					next_s.strobe_n = 1'b0;
				end else begin
					next_s.wr_dir = 1'b0;
				end
			end
			H_STRB: begin
				// wait for the device, however long it takes
				if (!bus.ready_n) begin
					next_s.st       = H_END;
					next_s.strobe_n = 1'b1;
					next_s.wr_dir   = dir ? s.wr_dir : 1'b1;
					if (s.cmd_rd) begin
						next_s.rbyte = bus.ad;
					end
				end
			end
			H_END: begin
				next_s.st     = H_IDLE;
				next_s.cs_n   = 1'b1;
				next_s.ad_oe  = 1'b0;
				next_s.wr_dir = 1'b1;
				ev[INT_DONE]  = 1'b1;
			end
			default: begin
				next_s.st = H_IDLE;
			end
		endcase
		// a new event beats a clear in the same cycle
		next_s.istat = (s.istat & ~clr) | ev;
		next_s.irq   = |(next_s.istat & s.ien);
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			s <= H_RST;
		end else begin
			s <= next_s;
		end
	end

	assign BVALID              = s.bvalid;
	assign BRESP               = s.bresp;
	assign RVALID              = s.rvalid;
	assign RDATA               = s.rdata;
	assign RRESP               = s.rresp;
	assign IRQ                 = s.irq;
	assign bus.ale             = s.ale;
	assign bus.cs_n            = s.cs_n;
	assign bus.wr_dir          = s.wr_dir;
	assign bus.strobe_n        = s.strobe_n;
	assign bus.addr            = s.addr;
	assign bus.host_ad_o       = s.ad_o;
	assign bus.host_ad_oe      = s.ad_oe;
	assign bus.host_bus_select = s.cfg[2:0];
endmodule

// file: verif/ppbp_checker.sv
// checker for the device end of the parallel port pins
// assumes: one clock; device reset active high; mode pins steady at reset release
`timescale 1ns/1ps
module ppbp_checker (
	input wire logic       CLK,
	input wire logic       RST,
	input wire logic       cs_n,
	input wire logic       wr_dir,
	input wire logic       strobe_n,
	input wire logic       dev_ad_oe,
	input wire logic       ready_n,
	input wire logic [2:0] host_bus_select
);
	logic [2:0] mode;
	logic       armed;
	logic       strobe_on;
	logic       rd_sel;
	logic       rd_take;

	default clocking @(posedge CLK); endclocking
	default disable iff (RST);

	// own copy of the mode, taken like the device does at the first edge
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			armed <= 1'b0;
			mode  <= 3'h0;
		end else if (!armed) begin
			armed <= 1'b1;
			mode  <= host_bus_select;
		end
	end

	// pair style writes with wr_dir, direction style only with the data strobe
	assign strobe_on = mode[2] ? !strobe_n : (!strobe_n || !wr_dir);
	assign rd_sel    = !cs_n && wr_dir;
	assign rd_take   = !cs_n && !strobe_n;

	oe_read_only_a: assert property (dev_ad_oe |-> $past(rd_sel))
		else $error("shared lines driven outside a read");
	oe_after_strobe_a: assert property ($rose(dev_ad_oe) |-> $past(rd_take))
		else $error("read drive without a read strobe");
	read_ready_a: assert property ($rose(dev_ad_oe) |=> $fell(ready_n))
		else $error("read ready not one cycle after drive");
	ready_selected_a: assert property ($fell(ready_n) |-> !$past(cs_n))
		else $error("ready given while not selected");
	ready_hold_a: assert property ((!ready_n && !cs_n && strobe_on) |=> !ready_n)
		else $error("ready dropped while strobe held");
	ready_drop_a: assert property ((!ready_n && !strobe_on) |-> ##[1:2] ready_n)
		else $error("ready not released after strobe");
	oe_drop_a: assert property ((dev_ad_oe && (cs_n || strobe_n)) |-> ##[1:2] !dev_ad_oe)
		else $error("shared lines not released");
	write_quiet_a: assert property ((!cs_n && !wr_dir) |-> !dev_ad_oe)
		else $error("device drives during a write");
	idle_quiet_a: assert property (cs_n [*3] |-> (ready_n && !dev_ad_oe))
		else $error("activity while deselected");

	cover property ($rose(dev_ad_oe));
	cover property ($fell(ready_n) && !wr_dir);
	cover property (armed && mode[2] && $fell(ready_n));
endmodule

// file: verif/test_parallel_processor_bus_port.sv
// self-checking bench: host and device ends joined by the pin interface
// assumes: AXI4-Lite master here; a user register file sits behind the device
`timescale 1ns/1ps
module test_parallel_processor_bus_port;
	import ppbp_pkg::*;
	logic        clk, rst_host, rst_dev, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, irq, reg_wr, reg_rd;
	logic [7:0]  awaddr, araddr, reg_wdata, reg_rdata, irq_events, v8;
	logic [31:0] wdata, rdata, seed, d;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, r;
	logic [8:0]  reg_addr, a9, b9;
	logic [2:0]  bus_mode;
	logic [7:0]  user_mem [512];
	int          model [512];
	int          fails, n_tests;
	logic [2:0]  modes [4] = '{SEL_MUX_PAIR, SEL_NMX_PAIR, SEL_NMX_DIR, SEL_MUX_DIR};
	logic [7:0]  cfgs [5] = '{8'h1, 8'h2, 8'hc, 8'h4, 8'h3};
	logic        pins [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

	ppbp_if u_ppbp_if ();
	ppbp_dev u_ppbp_dev (.CLK(clk), .RST(rst_dev), .bus(u_ppbp_if), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
		.IRQ_EVENTS(irq_events), .BUS_MODE(bus_mode));
	ppbp_host u_ppbp_host (.CLK(clk), .RST(rst_host), .bus(u_ppbp_if), .AWVALID(awvalid),
		.AWREADY(awready), .AWADDR(awaddr), .WVALID(wvalid), .WREADY(wready), .WDATA(wdata),
		.WSTRB(wstrb), .BVALID(bvalid), .BREADY(bready), .BRESP(bresp), .ARVALID(arvalid),
		.ARREADY(arready), .ARADDR(araddr), .RVALID(rvalid), .RREADY(rready), .RDATA(rdata),
		.RRESP(rresp), .IRQ(irq));
	ppbp_checker u_ppbp_checker (.CLK(clk), .RST(rst_dev), .cs_n(u_ppbp_if.cs_n),
		.wr_dir(u_ppbp_if.wr_dir), .strobe_n(u_ppbp_if.strobe_n),
		.dev_ad_oe(u_ppbp_if.dev_ad_oe), .ready_n(u_ppbp_if.ready_n),
		.host_bus_select(u_ppbp_if.host_bus_select));

	// user register file answers in the read pulse cycle, as the device expects
	assign reg_rdata = user_mem[reg_addr];
	always @(posedge clk) begin
		if (reg_wr) user_mem[reg_addr] <= reg_wdata;
	end

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		xs = x ^ (x << 5);
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// ready is judged at the falling edge, where it is settled for the next rise
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		logic ta, tw, tb;
		tb = 1'b0;
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= v;
		for (int n = 0; n < 200 && !tb; n++) begin
			@(negedge clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			rs = bresp;
			@(posedge clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end
		if (!tb) chk(32'h0, 32'h1);
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		logic ta, tr;
		tr = 1'b0;
		arvalid <= 1'b1;
		araddr <= a;
		for (int n = 0; n < 200 && !tr; n++) begin
			@(negedge clk);
			ta = arvalid && arready;
			tr = rvalid;
			v = rdata;
			rs = rresp;
			@(posedge clk);
			if (ta) arvalid <= 1'b0;
		end
		if (!tr) chk(32'h0, 32'h1);
	endtask

	// poll the busy flag; bounded so a stuck link shows as a mismatch
	task automatic idle_wait;
		logic [31:0] s;
		logic [1:0]  q;
		s = 32'h1;
		for (int n = 0; n < 50 && s[0]; n++) axi_rd(HOST_STATUS, s, q);
		chk(s[0], 32'h0);
	endtask

	task automatic link_wr(input logic [8:0] a, input logic [7:0] v);
		axi_wr(HOST_WDATA, {24'h0, v}, r);
		axi_wr(HOST_CMD, {23'h0, a}, r);
		chk(r, RESP_OKAY);
		idle_wait();
	endtask

	task automatic link_rd(input logic [8:0] a, output logic [7:0] v);
		axi_wr(HOST_CMD, {22'h0, 1'b1, a}, r);
		idle_wait();
		axi_rd(HOST_RDATA, d, r);
		chk(r, RESP_OKAY);
		v = d[7:0];
	endtask

	// mode pins only count at device reset, so the host stays out of reset
	task automatic dev_mode(input logic [2:0] m);
		axi_wr(HOST_CFG, {29'h0, m}, r);
		rst_dev <= 1'b1;
		repeat (2) @(posedge clk);
		rst_dev <= 1'b0;
		repeat (3) @(posedge clk);
		chk(bus_mode, m);
	endtask

	initial begin
		#200000;
		fails++;
		final_report();
	end

	initial begin
		rst_host = 1'b1;
		rst_dev = 1'b1;
		{awvalid, wvalid, arvalid, awaddr, araddr, wdata, irq_events} = '0;
		bready = 1'b1;
		rready = 1'b1;
		wstrb = 4'hf;
		seed = 32'h9638f237;
		fails = 0;
		n_tests = 0;
		for (int i = 0; i < 512; i++) begin
			user_mem[i] = 8'(i);
			model[i] = i & 255;
		end
		repeat (8) @(posedge clk);
		rst_host <= 1'b0;
		rst_dev <= 1'b0;
		repeat (2) @(posedge clk);
		chk(bus_mode, SEL_NMX_PAIR);
		axi_rd(HOST_CFG, d, r);
		chk(d, {28'h0, HOST_CFG_RST});
		// random traffic in every mode; both halves of the address space
		foreach (modes[k]) begin
			dev_mode(modes[k]);
			for (int j = 0; j < 4; j++) begin
				seed = xs(seed);
				a9 = {seed[8], seed[7:0] % 8'hfc};
				b9 = {~a9[8], a9[7:0]};
				model[a9] = seed[23:16];
				link_wr(a9, seed[23:16]);
				chk(user_mem[a9], model[a9]);
				link_rd(b9, v8);
				chk(v8, model[b9]);
				link_rd(a9, v8);
				chk(v8, model[a9]);
			end
		end
		axi_wr(8'h40, 32'h1, r);
		chk(r, RESP_SLVERR);
		axi_rd(8'h44, d, r);
		chk({d, r}, {32'h0, RESP_SLVERR});
		// refused mode: the device stays quiet, so the stuck host needs its own reset
		dev_mode(3'h0);
		axi_wr(HOST_CMD, 32'h2ff, r);
		repeat (20) @(posedge clk);
		chk({u_ppbp_if.ready_n, u_ppbp_if.dev_ad_oe, reg_rd}, 32'h4);
		rst_host <= 1'b1;
		rst_dev <= 1'b1;
		repeat (2) @(posedge clk);
		rst_host <= 1'b0;
		rst_dev <= 1'b0;
		repeat (3) @(posedge clk);
		chk(bus_mode, SEL_NMX_PAIR);
		// interrupt pin: raise, mask, polarity, drive kind, general output, clear
		link_rd(DEV_IRQ_CONFIG, v8);
		chk(v8, IRQ_CONFIG_RST);
		link_wr(DEV_IRQ_ENABLE, 8'h1);
		irq_events <= 8'h1;
		@(posedge clk);
		irq_events <= 8'h0;
		repeat (3) @(posedge clk);
		chk(u_ppbp_if.irq_pin, 32'h0);
		link_rd(DEV_IRQ_STATUS, v8);
		chk(v8, 32'h1);
		link_wr(DEV_IRQ_ENABLE, 8'h0);
		chk(u_ppbp_if.irq_pin, 32'h1);
		// drop the sticky pin event first so the next raise must come from the device interrupt pin
		axi_wr(HOST_INT_CLEAR, 32'h2, r);
		axi_wr(HOST_INT_ENABLE, 32'h2, r);
		chk(irq, 32'h0);
		link_wr(DEV_IRQ_ENABLE, 8'h1);
		chk(irq, 32'h1);
		foreach (cfgs[k]) begin
			link_wr(DEV_IRQ_CONFIG, cfgs[k]);
			chk(u_ppbp_if.irq_pin, pins[k]);
		end
		chk(u_ppbp_if.irq_oe, 32'h0);
		link_wr(DEV_IRQ_CONFIG, 8'h0);
		link_wr(DEV_IRQ_CLEAR, 8'h1);
		link_rd(DEV_IRQ_STATUS, v8);
		chk({v8, u_ppbp_if.irq_pin}, 32'h1);
		axi_rd(HOST_INT_STATUS, d, r);
		chk(d, 32'h3);
		axi_wr(HOST_INT_CLEAR, 32'h3, r);
		repeat (3) @(posedge clk);
		chk(irq, 32'h0);
		final_report();
	end
endmodule
